//--- common/bsr_cfg.svh
// Constants for the burst static RAM bus interface
`ifndef BSR_CFG_SVH
`define BSR_CFG_SVH
`define BSR_ADDR_W 16
`define BSR_DEPTH 65536
`define BSR_DATA_W 18
`define BSR_LANE_W 9
`define BSR_LOW_LANE 0
`define BSR_HIGH_LANE 1
`define BSR_BUF_DEPTH 2
`define BSR_CLK_PERIOD_NS 25
`endif

//--- common/bsr_pkg.sv
// Types for the burst static RAM bus interface
package bsr_pkg;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_SNOOZE = 2'b10
	} bsr_state_t;
	typedef enum logic [1:0]
	{
		OP_NONE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b10
	} bsr_op_t;
endpackage

//--- hw/bsr_buf2.sv
// Two-entry valid/ready buffer carrying read words to the output stage
`timescale 1ns/1ps
`include "bsr_cfg.svh"
module bsr_buf2
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [`BSR_DATA_W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [`BSR_DATA_W-1:0] out_data
);
	logic [`BSR_DATA_W-1:0] mem_q [0:`BSR_BUF_DEPTH-1];
	logic rd_q;
	logic wr_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			if (push && !pop)
				cnt_q <= cnt_q + 2'h1;
			else if (pop && !push)
				cnt_q <= cnt_q - 2'h1;
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end
	a_buf_no_over: assert property (@(posedge clk) disable iff (rst) cnt_q <= 2'h2)
		else $error("buffer count above two");
	a_buf_full_stall: assert property (@(posedge clk) disable iff (rst)
		(cnt_q == 2'h2 && !out_ready) |=> cnt_q == 2'h2)
		else $error("full buffer lost a word");
endmodule // bsr_buf2

//--- hw/bsr_sram_if.sv
// Synchronous burst static RAM bus interface with array
`timescale 1ns/1ps
`include "bsr_cfg.svh"
// Behaviour
// (R01) Register all synchronous inputs on rising edge
// (R02) Array of 65536 words, 18 bits
// (R03) Two-bit burst counter forms low address
// (R04) Low enable: low byte, high enable: high
// (R05) Global write beats lanes; qualifier gates lanes
// (R06) Processor strobe loads address, forces read
// (R07) Controller strobe loads address, read or write
// (R08) Controller strobe with enable high deselects
// (R09) Advance low steps counter, high waits
// (R10) Master holds advance high before strobe write
// (R11) Chip enables sampled only at address load
// (R12) Snooze retains array, ignores other inputs
// (R13) Output enable gates data drivers
// (R14) Any lane write sampled low floats data
// (R15) Order select low linear, high interleaved
// (R16) Master keeps order select constant
// (R17) Interleaved order: start XOR step count
// (R18) Linear order: start plus step modulo four
// (R19) Parity bits exist only on wide variant
// (R20) Writes complete self-timed, no extra strobes
// (R21) Processor strobe cycle starts as read
// (R22) Both strobes high: continue or suspend burst
// (R23) Read data flow through without output stage; here the two-entry buffer feeds a registered output
module bsr_sram_if
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Address and selects
	input wire logic [`BSR_ADDR_W-1:0] WORD_ADDRESS,
	input wire logic MAIN_SELECT_N,
	input wire logic SECOND_SELECT_N,
	input wire logic THIRD_SELECT_HI,
	// Burst control
	input wire logic PROC_ADDR_STROBE_N,
	input wire logic CTRL_ADDR_STROBE_N,
	input wire logic BURST_ADVANCE_N,
	input wire logic BURST_ORDER_SEL,
	// Write control
	input wire logic LOW_LANE_WRITE_N,
	input wire logic HIGH_LANE_WRITE_N,
	input wire logic LANE_WRITE_QUALIFIER_N,
	input wire logic ALL_LANES_WRITE_N,
	// Asynchronous controls
	input wire logic OUTPUT_ENABLE_N,
	input wire logic SNOOZE_REQUEST,
	// Data pins, bits 8 and 17 are the parity bits
	input wire logic [`BSR_DATA_W-1:0] DATA_PINS_IN,
	output logic [`BSR_DATA_W-1:0] DATA_PINS_OUT,
	output logic DATA_PINS_OE,
	// Status
	output logic POWER_DOWN,
	output logic SNOOZE_ACTIVE
);
	// ****************************************
	// Input registers
	// ****************************************
	// Pins come from outside the clock domain, so two stages each
	localparam int IW = `BSR_ADDR_W + 3 + 4 + 4 + 2;
	logic [IW-1:0] s1_q;
	logic [IW-1:0] s2_q;
	logic [`BSR_DATA_W-1:0] din1_q;
	logic [`BSR_DATA_W-1:0] din_q;
	logic [IW-1:0] pins;
	assign pins = {WORD_ADDRESS, MAIN_SELECT_N, SECOND_SELECT_N, THIRD_SELECT_HI,
		PROC_ADDR_STROBE_N, CTRL_ADDR_STROBE_N, BURST_ADVANCE_N, BURST_ORDER_SEL,
		LOW_LANE_WRITE_N, HIGH_LANE_WRITE_N, LANE_WRITE_QUALIFIER_N, ALL_LANES_WRITE_N,
		OUTPUT_ENABLE_N, SNOOZE_REQUEST};
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			s1_q <= '1;
			s2_q <= '1;
			din1_q <= '0;
			din_q <= '0;
		end
		else
		begin
			s1_q <= pins; // see (R01)
			s2_q <= s1_q;
			din1_q <= DATA_PINS_IN;
			din_q <= din1_q;
		end
	end
	logic [`BSR_ADDR_W-1:0] addr_s;
	logic ce_n_s, sel2_n_s, sel3_s, pstb_n_s, cstb_n_s, advance_n_s, mode_s;
	logic lo_wr_n_s, hi_wr_n_s, qual_n_s, all_wr_n_s, oe_n_s, snooze_s;
	assign {addr_s, ce_n_s, sel2_n_s, sel3_s, pstb_n_s, cstb_n_s, advance_n_s, mode_s,
		lo_wr_n_s, hi_wr_n_s, qual_n_s, all_wr_n_s, oe_n_s, snooze_s} = s2_q;

	// ****************************************
	// Decode functions
	// ****************************************
	function automatic logic [1:0] lane_mask(input logic all_n, input logic qual_n,
		input logic lo_n, input logic hi_n);
		logic [1:0] m;
		m = 2'h0;
		if (!all_n)
			m = 2'h3; // see (R05)
		else if (!qual_n)
			m = {~hi_n, ~lo_n}; // see (R05) see (R04)
		return m;
	endfunction
	function automatic logic [1:0] burst_low(input logic mode, input logic [1:0] start,
		input logic [1:0] step);
		logic [1:0] r;
		r = mode ? (start ^ step) : 2'(start + step); // see (R15) see (R17) see (R18)
		return r;
	endfunction

	// ****************************************
	// Address and burst state
	// ****************************************
	bsr_pkg::bsr_state_t state_q;
	logic [`BSR_ADDR_W-1:0] base_q;
	logic [1:0] step_q;
	logic proc_cycle_q;
	logic selected;
	logic load_proc;
	logic load_ctrl;
	logic [1:0] lanes_s;
	// Processor strobe is gated by the main enable only
	assign selected = !ce_n_s && !sel2_n_s && sel3_s; // see (R11)
	assign load_proc = !pstb_n_s && !ce_n_s; // see (R06)
	assign load_ctrl = !load_proc && !cstb_n_s; // see (R07) see (R08)
	assign lanes_s = lane_mask(all_wr_n_s, qual_n_s, lo_wr_n_s, hi_wr_n_s);
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_q <= bsr_pkg::ST_IDLE;
			base_q <= '0;
			step_q <= 2'h0;
			proc_cycle_q <= 1'b0;
		end
		else if (snooze_s)
			state_q <= bsr_pkg::ST_SNOOZE; // see (R12)
		else if (load_proc || load_ctrl)
		begin
			base_q <= addr_s; // see (R06) see (R07)
			step_q <= 2'h0;
			proc_cycle_q <= load_proc;
			state_q <= (selected && !ce_n_s) ? bsr_pkg::ST_ACTIVE : bsr_pkg::ST_IDLE; // see (R08) see (R11)
		end
		else
		begin
			case (state_q)
				bsr_pkg::ST_ACTIVE:
				begin
					proc_cycle_q <= 1'b0;
					if (!advance_n_s)
						step_q <= step_q + 2'h1; // see (R09) see (R22) see (R03)
				end
				bsr_pkg::ST_SNOOZE:
					state_q <= bsr_pkg::ST_IDLE;
				bsr_pkg::ST_IDLE:
					state_q <= bsr_pkg::ST_IDLE;
				default:
					state_q <= bsr_pkg::ST_IDLE;
			endcase
		end
	end
	logic [`BSR_ADDR_W-1:0] cur_addr;
	assign cur_addr = {base_q[`BSR_ADDR_W-1:2], burst_low(mode_s, base_q[1:0], step_q)};

	// ****************************************
	// Operation decode for current cycle
	// ****************************************
	// A write in a processor burst lands on the next edge, at the held address
	bsr_pkg::bsr_op_t op;
	logic [1:0] wr_lanes;
	logic cont;
	assign cont = pstb_n_s && cstb_n_s && state_q == bsr_pkg::ST_ACTIVE;
	always_comb
	begin
		op = bsr_pkg::OP_NONE;
		wr_lanes = 2'h0;
		if (!snooze_s && state_q == bsr_pkg::ST_ACTIVE)
		begin
			if (proc_cycle_q && !cont)
				op = bsr_pkg::OP_READ; // see (R21)
			else if (lanes_s != 2'h0 && !(load_proc || load_ctrl))
			begin
				op = bsr_pkg::OP_WRITE; // see (R10) see (R20)
				wr_lanes = lanes_s;
			end
			else
				op = bsr_pkg::OP_READ;
		end
	end

	// ****************************************
	// Storage array
	// ****************************************
	// Parity columns kept; a narrow build simply leaves them unused
	logic [`BSR_DATA_W-1:0] mem_q [0:`BSR_DEPTH-1]; // see (R02) see (R19)
	always_ff @(posedge SYS_CLK)
	begin
		if (op == bsr_pkg::OP_WRITE)
		begin
			if (wr_lanes[`BSR_LOW_LANE])
				mem_q[cur_addr][`BSR_LANE_W-1:0] <= din_q[`BSR_LANE_W-1:0]; // see (R04)
			if (wr_lanes[`BSR_HIGH_LANE])
				mem_q[cur_addr][`BSR_DATA_W-1:`BSR_LANE_W] <= din_q[`BSR_DATA_W-1:`BSR_LANE_W]; // see (R04)
		end
	end

	// ****************************************
	// Read path through two-entry buffer
	// ****************************************
	// Buffer drains every cycle, so flow-through latency stays one word
	logic rd_valid;
	logic rd_ready;
	logic out_valid;
	logic [`BSR_DATA_W-1:0] out_data;
	assign rd_valid = op == bsr_pkg::OP_READ; // see (R23)
	bsr_buf2 u_buf
	(
		.clk(SYS_CLK),
		.rst(RESET),
		.in_valid(rd_valid),
		.in_ready(rd_ready),
		.in_data(mem_q[cur_addr]),
		.out_valid(out_valid),
		.out_ready(1'b1),
		.out_data(out_data)
	);
	logic drive;
	assign drive = out_valid && !oe_n_s && lo_wr_n_s && hi_wr_n_s && !snooze_s; // see (R13) see (R14)
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			DATA_PINS_OUT <= '0;
			DATA_PINS_OE <= 1'b0;
			POWER_DOWN <= 1'b1;
			SNOOZE_ACTIVE <= 1'b0;
		end
		else
		begin
			DATA_PINS_OUT <= out_data;
			DATA_PINS_OE <= drive && rd_ready;
			POWER_DOWN <= state_q != bsr_pkg::ST_ACTIVE; // see (R08)
			SNOOZE_ACTIVE <= state_q == bsr_pkg::ST_SNOOZE; // see (R12)
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_snooze_quiet: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R12)
		state_q == bsr_pkg::ST_SNOOZE |-> op == bsr_pkg::OP_NONE)
		else $error("access during snooze");
	a_lane_float: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R14)
		(!lo_wr_n_s || !hi_wr_n_s) |=> !DATA_PINS_OE)
		else $error("data driven during lane write");
	a_oe_gate: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R13)
		oe_n_s |=> !DATA_PINS_OE)
		else $error("data driven with output enable high");
	a_proc_read: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R06)
		(load_proc && selected && !snooze_s) |=> (state_q == bsr_pkg::ST_ACTIVE && step_q == 2'h0))
		else $error("processor strobe did not load");
	a_deselect: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R08)
		(!cstb_n_s && pstb_n_s && ce_n_s && !snooze_s) |=> state_q == bsr_pkg::ST_IDLE)
		else $error("controller strobe did not deselect");
	a_burst_step: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R09)
		(cont && !advance_n_s && !snooze_s) |=> step_q == $past(step_q) + 2'h1)
		else $error("burst did not advance");
	a_burst_hold: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R22)
		(cont && advance_n_s && !snooze_s) |=> step_q == $past(step_q))
		else $error("burst moved during wait");
	a_global_write: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R05)
		!all_wr_n_s |-> lanes_s == 2'h3)
		else $error("global write not all lanes");
	a_interleave: assert property (@(posedge SYS_CLK) disable iff (RESET) // see (R17)
		mode_s |-> cur_addr[1:0] == (base_q[1:0] ^ step_q))
		else $error("interleaved address wrong");
	c_proc_burst: cover property (@(posedge SYS_CLK) load_proc ##1 cont && !advance_n_s);
	c_ctrl_write: cover property (@(posedge SYS_CLK) op == bsr_pkg::OP_WRITE);
	c_snooze: cover property (@(posedge SYS_CLK) state_q == bsr_pkg::ST_SNOOZE);
endmodule // bsr_sram_if

//--- test/bsr_master.sv
// Bus master model for the burst static RAM pins
`timescale 1ns/1ps
module bsr_master
(
	// Clock
	input wire logic clk,
	// Bus pins
	output logic [15:0] addr,
	output logic sel_n,
	output logic ps_n,
	output logic cs_n,
	output logic advance_n,
	output logic [3:0] wr_n,
	output logic [17:0] dout
);
	// ****
	// Pin cycle
	// ****
	initial
	begin
		{addr, sel_n, ps_n, cs_n, advance_n, wr_n, dout} = {16'h0, 4'hF, 4'hF, 18'h0};
	end
	// Advance forced high so a write after a processor load keeps its address
	task automatic cyc(input logic p, input logic c, input logic a, input logic s, input logic [3:0] w,
		input logic [17:0] d, input logic [15:0] ad);
		@(posedge clk);
		advance_n <= (!ps_n && w != 4'hF) ? 1'h1 : a;
		dout <= (w == 4'hF) ? ~dout : d;
		{ps_n, cs_n, sel_n, wr_n, addr} <= {p, c, s, w, ad};
	endtask
endmodule // bsr_master

//--- test/testbench.sv
// Self-checking bench for the burst static RAM bus interface
`timescale 1ns/1ps
module testbench;
	// ****
	// Signals
	// ****
	typedef struct packed { logic m; logic [1:0] s; logic [7:0] seq; } bsr_row_t;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic mode = 1'h0;
	logic oe_n = 1'h0;
	logic snooze = 1'h0;
	logic sel2_n = 1'h0;
	logic sel3 = 1'h1;
	logic [15:0] addr;
	logic sel_n, ps_n, cs_n, advance_n, oe, pdn, snz;
	logic [3:0] wr_n;
	logic [17:0] din, dout;
	logic [17:0] q[$];
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	// Order select, start, low address bits of the four beats
	bsr_row_t rows [8] = '{'{1'h0, 2'h0, 8'h1B}, '{1'h0, 2'h1, 8'h6C}, '{1'h0, 2'h2, 8'hB1},
		'{1'h0, 2'h3, 8'hC6}, '{1'h1, 2'h0, 8'h1B}, '{1'h1, 2'h1, 8'h4E}, '{1'h1, 2'h2, 8'hB1},
		'{1'h1, 2'h3, 8'hE4}};
	logic [3:0] lw [4] = '{4'hA, 4'h9, 4'hC, 4'h8};
	logic [17:0] ld [4] = '{18'h15555, 18'h0, 18'h3FFFF, 18'h2AAAA};
	logic [17:0] le [4] = '{18'h3FF55, 18'h00155, 18'h00155, 18'h2AAAA};
	// ****
	// Design and master
	// ****
	bsr_master u_bsr_master (.clk(clk), .addr(addr), .sel_n(sel_n), .ps_n(ps_n), .cs_n(cs_n), .advance_n(advance_n),
		.wr_n(wr_n), .dout(din));
	bsr_sram_if u_bsr_sram_if (.SYS_CLK(clk), .RESET(rst), .WORD_ADDRESS(addr), .MAIN_SELECT_N(sel_n),
		.SECOND_SELECT_N(sel2_n), .THIRD_SELECT_HI(sel3), .PROC_ADDR_STROBE_N(ps_n), .CTRL_ADDR_STROBE_N(cs_n),
		.BURST_ADVANCE_N(advance_n), .BURST_ORDER_SEL(mode), .LOW_LANE_WRITE_N(wr_n[0]),
		.HIGH_LANE_WRITE_N(wr_n[1]), .LANE_WRITE_QUALIFIER_N(wr_n[2]), .ALL_LANES_WRITE_N(wr_n[3]),
		.OUTPUT_ENABLE_N(oe_n), .SNOOZE_REQUEST(snooze), .DATA_PINS_IN(din), .DATA_PINS_OUT(dout),
		.DATA_PINS_OE(oe), .POWER_DOWN(pdn), .SNOOZE_ACTIVE(snz));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	// Words are gathered whenever driven, so latency need not be known
	always @(posedge clk)
	begin
		cycles++;
		if (oe === 1'h1)
			q.push_back(dout);
		if (cycles == 20000)
		begin
			n_fail++;
			complete_run();
		end
	end
	// ****
	// Tasks
	// ****
	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [17:0] dat(input logic [1:0] i);
		return 18'h3A500 ^ (18'h01111 * 18'(i));
	endfunction
	task automatic idle(input int n);
		repeat (n) u_bsr_master.cyc(1'h1, 1'h0, 1'h1, 1'h1, 4'hF, 18'h0, 16'h0);
	endtask
	task automatic wr(input logic [15:0] a, input logic [3:0] w, input logic [17:0] d);
		u_bsr_master.cyc(1'h1, 1'h0, 1'h1, 1'h0, 4'hF, 18'h0, a);
		u_bsr_master.cyc(1'h1, 1'h1, 1'h1, 1'h0, w, d, 16'h0);
	endtask
	// Main select dropped in beats: burst must carry on regardless
	// Leading idles drain words of earlier cycles before the queue is cleared
	task automatic rd(input logic [15:0] a, input int n);
		idle(8);
		q.delete();
		u_bsr_master.cyc(1'h0, 1'h1, 1'h1, 1'h0, 4'hF, 18'h0, a);
		repeat (n - 1) u_bsr_master.cyc(1'h1, 1'h1, 1'h0, 1'h1, 4'hF, 18'h0, 16'h0);
		idle(8);
	endtask
	task automatic reset_to(input logic m);
		rst <= 1'h1;
		mode <= m;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
	endtask
	// ****
	// Sequence
	// ****
	initial
	begin
		repeat (5) @(posedge clk);
		check("reset oe", 18'(oe), 18'h0);
		check("reset pdn", 18'(pdn), 18'h1);
		$display("reset test done");
		foreach (rows[i])
		begin
			if (i == 0 || rows[i].m != mode)
			begin
				reset_to(rows[i].m);
				for (int k = 0; k < 4; k++)
					wr(16'h1230 + 16'(k), 4'h7, dat(2'(k)));
			end
			rd(16'h1230 + 16'(rows[i].s), 4);
			check("beats", 18'(q.size()), 18'h4);
			for (int k = 0; k < 4; k++)
				check("beat", q[k], dat(rows[i].seq[7 - 2 * k -: 2]));
			$display("order row %0d done", i);
		end
		wr(16'h0040, 4'h7, 18'h3FFFF);
		foreach (lw[i])
		begin
			wr(16'h0040, lw[i], ld[i]);
			idle(2);
			rd(16'h0040, 1);
			check("lane", q[0], le[i]);
		end
		$display("lane test done");
		u_bsr_master.cyc(1'h0, 1'h1, 1'h1, 1'h0, 4'hF, 18'h0, 16'h0050);
		u_bsr_master.cyc(1'h1, 1'h1, 1'h0, 1'h1, 4'h7, 18'h2D2D2, 16'h0);
		idle(6);
		q.delete();
		u_bsr_master.cyc(1'h0, 1'h1, 1'h1, 1'h0, 4'h7, 18'h0, 16'h0050);
		idle(8);
		check("proc write", q[0], 18'h2D2D2);
		$display("processor strobe test done");
		oe_n <= 1'h1;
		rd(16'h0050, 1);
		check("oe off", 18'(q.size()), 18'h0);
		check("deselect", 18'(pdn), 18'h1);
		oe_n <= 1'h0;
		$display("output enable test done");
		sel3 <= 1'h0;
		rd(16'h0050, 1);
		check("third select", 18'(q.size()), 18'h0);
		sel3 <= 1'h1;
		sel2_n <= 1'h1;
		rd(16'h0050, 1);
		check("second select", 18'(q.size()), 18'h0);
		check("select pdn", 18'(pdn), 18'h1);
		sel2_n <= 1'h0;
		$display("chip enable test done");
		snooze <= 1'h1;
		for (int k = 0; k < 10 && snz !== 1'h1; k++)
			@(posedge clk);
		check("snooze", 18'(snz), 18'h1);
		wr(16'h0050, 4'h7, 18'h0);
		snooze <= 1'h0;
		idle(4);
		rd(16'h0050, 1);
		check("retain", q[0], 18'h2D2D2);
		$display("snooze test done");
		complete_run();
	end
endmodule // testbench
